// >>> hw/brightness_pwm.sv
`timescale 1ns/1ps
`default_nettype none

module brightness_pwm
	import disp_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Level in, drive out
	input  wire logic [2:0] level_i,
	output var  logic       led_enable_o
);

	logic [3:0] slot_q;

	// ------------------------------------------------------------
	// Fifteen-slot frame gives the on-time ratios exactly
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			slot_q <= 4'h0;
		end else if (slot_q == PWM_SLOTS - 4'h1) begin
			slot_q <= 4'h0;
		end else begin
			slot_q <= slot_q + 4'h1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			led_enable_o <= 1'b0;
		end else begin
			led_enable_o <= (slot_q < ON_SLOTS[level_i]); // see (R11) (R12)
		end
	end

endmodule : brightness_pwm

`default_nettype wire

// >>> hw/disp_ctrl_pkg.sv
package disp_ctrl_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int unsigned DIGITS      = 8;
	localparam int unsigned GLYPHS      = 16;
	localparam int unsigned GLYPH_ROWS  = 7;
	localparam int unsigned DOT_COLS    = 5;

	// ------------------------------------------------------------
	// Control word fields
	// ------------------------------------------------------------
	localparam int unsigned CW_BRIGHT_LSB = 0;
	localparam int unsigned CW_FLASH_EN   = 3;
	localparam int unsigned CW_BLINK_EN   = 4;
	localparam int unsigned CW_CLEAR      = 7;
	localparam logic [7:0]  CW_RESET      = 8'h00;
	localparam logic [2:0]  BRIGHT_BLANK  = 3'h7;

	// ------------------------------------------------------------
	// Reset values of the other stores
	// ------------------------------------------------------------
	localparam logic [7:0]  FLASH_RESET   = 8'h00;
	localparam logic [3:0]  PTR_RESET     = 4'h0;

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam logic [14:0] REFRESH_DIVIDE  = 15'h7000;
	localparam logic [14:0] FLASH_HALF      = 15'h3800;
	localparam logic [1:0]  CLEAR_TICKS     = 2'h3;
	localparam logic [7:0]  INT_REFRESH_HALF = 8'hAF;
	localparam logic [3:0]  PWM_SLOTS       = 4'hF;
	localparam logic [3:0]  ON_SLOTS [8] = '{4'hF, 4'hC, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h0};

	// ------------------------------------------------------------
	// Host access targets
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RGN_FLASH,
		RGN_PTR,
		RGN_ROW,
		RGN_CTRL,
		RGN_CHAR
	} region_t;

endpackage : disp_ctrl_pkg

// >>> hw/display_attribute_control_port.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R1) Eight one-bit flash attributes, one per character position.
// (R2) Attribute-select low reaches the flash store; upper two address lines ignored.
// (R3) Low three address lines pick the digit, 000 leftmost, 111 rightmost.
// (R4) Flash write stores data bit 0; other data bits ignored.
// (R5) Flagged digits toggle at refresh clock divided by 28,672 when flash enabled.
// (R6) Select high, upper lines 00: glyph pointer takes data bits 3..0.
// (R7) Select high, lines 01: glyph row, low lines 000..110 pick rows 1..7.
// (R8) Glyph row holds five dots in data 4..0, bit 4 leftmost.
// (R9) Select high, lines 10: control word; low lines ignored.
// (R10) Control word write updates all eight bits together.
// (R11) Bits 2..0 set intensity, 000 brightest, 111 blank.
// (R12) Codes 000..110 give 100,80,53,40,27,20,13 percent on-time.
// (R13) Bit 3 low ignores attributes; high honours them.
// (R14) Bit 4 high blinks all digits at refresh clock over 28,672.
// (R15) Whole-display blink overrides per-digit flash.
// (R16) Writing bit 7 high clears character and flash stores.
// (R17) Clear takes three refresh cycles, then bit 7 returns low.
// (R18) Host strobes write or read exclusively; both or neither is undefined.
// (R19) Host holds chip select low per cycle, high between cycles.
// (R20) One shared divider drives flash and blink in phase, 50 percent duty.
// (R21) Reads return stored values, unused bits zero.
module display_attribute_control_port
	import disp_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Host parallel port
	input  wire logic       cs_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       attribute_select_n_i,
	input  wire logic [4:0] addr_i,
	input  wire logic [7:0] data_i,
	output var  logic [7:0] data_o,
	output var  logic       data_oe_o,
	// Refresh clock
	input  wire logic       clock_source_select_i,
	input  wire logic       ext_refresh_clk_i,
	output var  logic       refresh_clk_o,
	// Display side
	output var  logic [7:0] digit_visible_o,
	output var  logic       led_enable_o,
	output var  logic       char_store_clear_o
);

	typedef enum logic {
		CLR_IDLE,
		CLR_RUN
	} clr_state_t;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic region_t region_of(input logic sel_n, input logic [1:0] upper);
		if (!sel_n) begin
			return RGN_FLASH; // see (R2)
		end
		case (upper)
			2'b00:   return RGN_PTR; // see (R6)
			2'b01:   return RGN_ROW; // see (R7)
			2'b10:   return RGN_CTRL; // see (R9)
			default: return RGN_CHAR;
		endcase
	endfunction : region_of

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [18:0] pin_s1_q;
	logic [18:0] pin_s2_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			// Idle pins: strobes high, refresh clock and source select low
			pin_s1_q <= 19'h0_000F;
			pin_s2_q <= 19'h0_000F;
		end else begin
			pin_s1_q <= {ext_refresh_clk_i, clock_source_select_i, data_i, addr_i,
				attribute_select_n_i, rd_n_i, wr_n_i, cs_n_i};
			pin_s2_q <= pin_s1_q;
		end
	end

	logic       cs_n_s;
	logic       wr_n_s;
	logic       rd_n_s;
	logic       sel_n_s;
	logic [4:0] addr_s;
	logic [7:0] data_s;
	logic       cls_s;
	logic       ext_clk_s;

	assign cs_n_s    = pin_s2_q[0];
	assign wr_n_s    = pin_s2_q[1];
	assign rd_n_s    = pin_s2_q[2];
	assign sel_n_s   = pin_s2_q[3];
	assign addr_s    = pin_s2_q[8:4];
	assign data_s    = pin_s2_q[16:9];
	assign cls_s     = pin_s2_q[17];
	assign ext_clk_s = pin_s2_q[18];

	// ------------------------------------------------------------
	// Access strobes
	// ------------------------------------------------------------
	// Both strobes low is undefined; it is simply not acted on
	logic    wr_act;
	logic    rd_act;
	logic    wr_act_q;
	logic    wr_go;
	region_t rgn;

	assign wr_act = !cs_n_s && !wr_n_s && rd_n_s; // see (R18)
	assign rd_act = !cs_n_s && wr_n_s && !rd_n_s; // see (R18)
	assign wr_go  = wr_act && !wr_act_q; // see (R19)
	assign rgn    = region_of(sel_n_s, addr_s[4:3]);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_act_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
		end
	end

	// ------------------------------------------------------------
	// Refresh clock source
	// ------------------------------------------------------------
	logic [7:0] int_div_q;
	logic       int_clk_q;
	logic       ext_clk_q;
	logic       int_clk_prev_q;
	logic       refresh_tick;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			int_div_q <= 8'h00;
			int_clk_q <= 1'b0;
		end else if (int_div_q == INT_REFRESH_HALF - 8'h01) begin
			int_div_q <= 8'h00;
			int_clk_q <= !int_clk_q;
		end else begin
			int_div_q <= int_div_q + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ext_clk_q      <= 1'b0;
			int_clk_prev_q <= 1'b0;
			refresh_clk_o  <= 1'b0;
		end else begin
			ext_clk_q      <= ext_clk_s;
			int_clk_prev_q <= int_clk_q;
			refresh_clk_o  <= cls_s && int_clk_q;
		end
	end

	// Each source keeps its own edge history, so a source switch gives no false tick
	assign refresh_tick = cls_s ? (int_clk_q && !int_clk_prev_q) : (ext_clk_s && !ext_clk_q);

	// ------------------------------------------------------------
	// Shared flash and blink divider
	// ------------------------------------------------------------
	logic [14:0] flash_cnt_q;
	logic        phase_on;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			flash_cnt_q <= 15'h0000;
		end else if (refresh_tick) begin
			if (flash_cnt_q == REFRESH_DIVIDE - 15'h0001) begin // see (R20)
				flash_cnt_q <= 15'h0000;
			end else begin
				flash_cnt_q <= flash_cnt_q + 15'h0001;
			end
		end
	end

	assign phase_on = (flash_cnt_q < FLASH_HALF); // see (R20)

	// ------------------------------------------------------------
	// Control word and clear sequence
	// ------------------------------------------------------------
	logic [7:0] ctrl_q;
	clr_state_t clr_state_q;
	logic [1:0] clr_cnt_q;
	logic       clr_start;
	logic       clr_done;

	assign clr_start = wr_go && rgn == RGN_CTRL && data_s[CW_CLEAR]; // see (R16)
	assign clr_done  = clr_state_q == CLR_RUN && refresh_tick && clr_cnt_q == CLEAR_TICKS - 2'h1;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= CW_RESET;
		end else if (wr_go && rgn == RGN_CTRL) begin
			// A fresh write wins over the self-clear of bit 7
			ctrl_q <= data_s; // see (R10)
		end else if (clr_done) begin
			ctrl_q[CW_CLEAR] <= 1'b0; // see (R17)
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			clr_state_q <= CLR_IDLE;
			clr_cnt_q   <= 2'h0;
		end else begin
			case (clr_state_q)
				CLR_IDLE: begin
					clr_cnt_q <= 2'h0;
					if (clr_start) begin
						clr_state_q <= CLR_RUN;
					end
				end
				CLR_RUN: begin
					if (clr_done) begin
						clr_state_q <= CLR_IDLE; // see (R17)
					end else if (refresh_tick) begin
						clr_cnt_q <= clr_cnt_q + 2'h1;
					end
				end
				default: clr_state_q <= CLR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			char_store_clear_o <= 1'b0;
		end else begin
			char_store_clear_o <= clr_start || (clr_state_q == CLR_RUN && !clr_done); // see (R16)
		end
	end

	// ------------------------------------------------------------
	// Flash attribute store
	// ------------------------------------------------------------
	logic [7:0] flash_q; // see (R1)

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			flash_q <= FLASH_RESET;
		end else if (clr_start) begin
			flash_q <= FLASH_RESET; // see (R16)
		end else if (wr_go && rgn == RGN_FLASH) begin
			flash_q[addr_s[2:0]] <= data_s[0]; // see (R3) (R4)
		end
	end

	// ------------------------------------------------------------
	// Custom glyph pointer and rows
	// ------------------------------------------------------------
	logic [3:0] ptr_q;
	logic [4:0] glyph_mem [GLYPHS * GLYPH_ROWS];
	logic [6:0] row_idx;
	logic       row_ok;

	assign row_ok  = addr_s[2:0] != 3'h7; // see (R7)
	assign row_idx = 7'({ptr_q, 3'h0} - {3'h0, ptr_q} + {4'h0, addr_s[2:0]});

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_q <= PTR_RESET;
		end else if (wr_go && rgn == RGN_PTR) begin
			ptr_q <= data_s[3:0]; // see (R6)
		end
	end

	// Glyph data is not reset: it is pattern storage, not control
	always_ff @(posedge clk_sys_i) begin
		if (wr_go && rgn == RGN_ROW && row_ok) begin
			glyph_mem[row_idx] <= data_s[DOT_COLS-1:0]; // see (R8)
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		case (rgn)
			RGN_FLASH: rd_mux = {7'h00, flash_q[addr_s[2:0]]}; // see (R21)
			RGN_PTR:   rd_mux = {4'h0, ptr_q}; // see (R21)
			RGN_ROW:   rd_mux = row_ok ? {3'h0, glyph_mem[row_idx]} : 8'h00;
			RGN_CTRL:  rd_mux = ctrl_q; // see (R21)
			default:   rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			data_o    <= 8'h00;
			data_oe_o <= 1'b0;
		end else begin
			data_o    <= rd_act ? rd_mux : 8'h00;
			data_oe_o <= rd_act;
		end
	end

	// ------------------------------------------------------------
	// Digit visibility and brightness
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			digit_visible_o <= 8'hFF;
		end else if (ctrl_q[CW_BLINK_EN]) begin
			digit_visible_o <= {DIGITS{phase_on}}; // see (R14) (R15)
		end else if (ctrl_q[CW_FLASH_EN]) begin
			digit_visible_o <= ~flash_q | {DIGITS{phase_on}}; // see (R5) (R13)
		end else begin
			digit_visible_o <= 8'hFF; // see (R13)
		end
	end

	brightness_pwm brightness_pwm_inst (
		.clk_sys_i    (clk_sys_i),
		.rst_i        (rst_i),
		.level_i      (ctrl_q[CW_BRIGHT_LSB +: 3]),
		.led_enable_o (led_enable_o)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [4:0] blank_run_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			blank_run_q <= 5'h00;
		end else if (ctrl_q[2:0] == BRIGHT_BLANK) begin
			blank_run_q <= (blank_run_q == 5'h1F) ? blank_run_q : blank_run_q + 5'h01;
		end else begin
			blank_run_q <= 5'h00;
		end
	end

	a_flash_store_write: assert property ( // see (R4)
		@(posedge clk_sys_i) disable iff (rst_i)
		(wr_go && rgn == RGN_FLASH && !clr_start)
		|=> flash_q[$past(addr_s[2:0])] == $past(data_s[0]))
		else $error("flash attribute not stored");

	a_pointer_write: assert property ( // see (R6)
		@(posedge clk_sys_i) disable iff (rst_i)
		(wr_go && rgn == RGN_PTR) |=> ptr_q == $past(data_s[3:0]))
		else $error("glyph pointer not loaded");

	a_ctrl_all_bits: assert property ( // see (R10)
		@(posedge clk_sys_i) disable iff (rst_i)
		(wr_go && rgn == RGN_CTRL) |=> ctrl_q == $past(data_s))
		else $error("control word not fully updated");

	a_clear_flash: assert property ( // see (R16)
		@(posedge clk_sys_i) disable iff (rst_i)
		clr_start |=> flash_q == FLASH_RESET && char_store_clear_o)
		else $error("clear did not empty stores");

	a_clear_ends: assert property ( // see (R17)
		@(posedge clk_sys_i) disable iff (rst_i)
		(clr_done && !(wr_go && rgn == RGN_CTRL)) |=> !ctrl_q[CW_CLEAR] && clr_state_q == CLR_IDLE)
		else $error("clear bit not returned low");

	a_divider_range: assert property ( // see (R20)
		@(posedge clk_sys_i) disable iff (rst_i)
		(refresh_tick && flash_cnt_q == REFRESH_DIVIDE - 15'h0001) |=> flash_cnt_q == 15'h0000)
		else $error("flash divider did not wrap");

	a_steady_no_flash: assert property ( // see (R13)
		@(posedge clk_sys_i) disable iff (rst_i)
		(!ctrl_q[CW_FLASH_EN] && !ctrl_q[CW_BLINK_EN]) |=> digit_visible_o == 8'hFF)
		else $error("digits not steady with flash off");

	a_blink_override: assert property ( // see (R15)
		@(posedge clk_sys_i) disable iff (rst_i)
		ctrl_q[CW_BLINK_EN] |=> digit_visible_o == {DIGITS{$past(phase_on)}})
		else $error("blink did not override flash");

	a_blank_level: assert property ( // see (R11)
		@(posedge clk_sys_i) disable iff (rst_i)
		(blank_run_q >= 5'h02) |-> !led_enable_o)
		else $error("blank level still drives leds");

	a_read_ptr_zero: assert property ( // see (R21)
		@(posedge clk_sys_i) disable iff (rst_i)
		(rd_act && rgn == RGN_PTR) |=> data_oe_o && data_o == {4'h0, $past(ptr_q)})
		else $error("pointer read wrong");

endmodule : display_attribute_control_port

`default_nettype wire

// >>> test/display_attribute_control_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module display_attribute_control_port_tb
	import disp_ctrl_pkg::*;
;
	logic       clk_sys_i;
	logic       rst_i;
	logic       cs_n;
	logic       wr_n;
	logic       rd_n;
	logic       sel_n;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       oe;
	logic       clock_source_select;
	logic       ext_clk;
	logic       refresh_clk;
	logic [7:0] visible;
	logic       led_en;
	logic       clr;
	int         num_errors;
	int         checks;
	int         seed;
	int         i;
	int         n;
	int         t;
	logic [7:0] d;
	logic [7:0] flags;
	logic [7:0] rows [7];
	logic [7:0] v;

	display_attribute_control_port display_attribute_control_port_inst (
		.clk_sys_i            (clk_sys_i),
		.rst_i                (rst_i),
		.cs_n_i               (cs_n),
		.wr_n_i               (wr_n),
		.rd_n_i               (rd_n),
		.attribute_select_n_i (sel_n),
		.addr_i               (addr),
		.data_i               (wdata),
		.data_o               (rdata),
		.data_oe_o            (oe),
		.clock_source_select_i(clock_source_select),
		.ext_refresh_clk_i    (ext_clk),
		.refresh_clk_o        (refresh_clk),
		.digit_visible_o      (visible),
		.led_enable_o         (led_en),
		.char_store_clear_o   (clr)
	);

	host_bus_model host_bus_model_inst (
		.clk_sys_i(clk_sys_i),
		.cs_n_o   (cs_n),
		.wr_n_o   (wr_n),
		.rd_n_o   (rd_n),
		.sel_n_o  (sel_n),
		.addr_o   (addr),
		.data_o   (wdata),
		.data_i   (rdata)
	);

	// ------------------------------------------------------------
	// Clocks
	// ------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	// Fastest external refresh the sampler can follow: one tick per two cycles
	initial begin
		ext_clk = 1'b0;
		forever begin
			@(posedge clk_sys_i);
			#1;
			ext_clk = ~ext_clk;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : compare

	task automatic wr(input logic s, input logic [4:0] a, input logic [7:0] dat);
		logic [7:0] r;
		host_bus_model_inst.cycle(s, a, 1'b1, dat, r);
	endtask : wr

	task automatic rd(input logic s, input logic [4:0] a, input string what, input logic [7:0] e);
		logic [7:0] r;
		fork
			host_bus_model_inst.cycle(s, a, 1'b0, 8'h00, r);
			begin
				// Read enable stands from the third edge after the pins settle
				repeat (5) @(posedge clk_sys_i);
				#1;
				compare("bus drive", 1, {31'h0, oe});
			end
		join
		compare(what, {24'h0, e}, {24'h0, r});
	endtask : rd

	task automatic wait_change(output int cnt);
		logic [7:0] old;
		old = visible;
		cnt = 0;
		while (visible === old && cnt < 30000) begin
			@(posedge clk_sys_i);
			#1;
			cnt++;
		end
	endtask : wait_change

	function automatic logic [7:0] flash_view(input logic [7:0] f, input logic shown);
		return shown ? 8'hFF : ~f;
	endfunction : flash_view

	function automatic int on_cycles(input int code, input int frames);
		return ON_SLOTS[code] * frames;
	endfunction : on_cycles

	task automatic results;
		$display("checks %0d, errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	initial begin
		// Three flash half periods of 28672 cycles dominate the run
		repeat (96000) @(posedge clk_sys_i);
		num_errors++;
		$display("unexpected timeout: expected end, seen hang");
		results();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed       = 32'hf23a;
		num_errors = 0;
		checks     = 0;
		rst_i      = 1'b1;
		clock_source_select        = 1'b0;
		repeat (16) @(posedge clk_sys_i);
		#1;
		rst_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		compare("bus drive", 0, {31'h0, oe});
		compare("refresh out", 0, {31'h0, refresh_clk});
		rd(1'b1, 5'h10, "control", CW_RESET);
		rd(1'b1, 5'h07, "pointer", 8'h00);
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			flags[i] = d[0];
			wr(1'b0, {d[7:6], i[2:0]}, d);
		end
		wr(1'b0, 5'h18, 8'hFE);
		wr(1'b0, 5'h07, 8'h01);
		flags[0] = 1'b0;
		flags[7] = 1'b1;
		for (i = 0; i < 8; i++) begin
			rd(1'b0, {i[1:0], i[2:0]}, "flash", {7'h00, flags[i]});
		end
		d = 8'($random(seed));
		wr(1'b1, {2'b00, d[6:4]}, d);
		rd(1'b1, {2'b00, ~d[6:4]}, "pointer", {4'h0, d[3:0]});
		for (i = 0; i < 7; i++) begin
			rows[i] = 8'($random(seed));
			wr(1'b1, {2'b01, i[2:0]}, rows[i]);
		end
		for (i = 0; i < 7; i++) begin
			rd(1'b1, {2'b01, i[2:0]}, "row", {3'h0, rows[i][4:0]});
		end
		rd(1'b1, 5'h0F, "row 7", 8'h00);
		wr(1'b1, 5'h1A, 8'h5A);
		rd(1'b1, 5'h1A, "char store", 8'h00);
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			d = {1'b0, d[6:5], 2'b00, i[2:0]};
			wr(1'b1, {2'b10, 3'(i + 3)}, d);
			rd(1'b1, {2'b10, 3'(i)}, "control", d);
			n = 0;
			repeat (150) begin
				@(posedge clk_sys_i);
				#1;
				n += (led_en === 1'b1) ? 1 : 0;
			end
			compare("on cycles", on_cycles(i, 10), n);
		end
		n = 0;
		repeat (300) begin
			@(posedge clk_sys_i);
			#1;
			n += (visible !== 8'hFF) ? 1 : 0;
		end
		compare("steady digits", 0, n);
		wr(1'b1, 5'h10, 8'h08);
		wait_change(t);
		v = visible;
		compare("flash view", flash_view(flags, v[7]), v);
		wait_change(t);
		compare("half period", 28672, t);
		v = visible;
		compare("flash view", flash_view(flags, v[7]), v);
		wr(1'b1, 5'h10, 8'h18);
		compare("blink view", {8{v[7]}}, visible);
		wait_change(t);
		compare("blink view", {8{~v[7]}}, visible);
		clock_source_select = 1'b1;
		wr(1'b1, 5'h10, 8'h8D);
		compare("clear running", 1, {31'h0, clr});
		n = 0;
		while (clr === 1'b1 && n < 1200) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		// Three ticks of 350 cycles, begun at an unknown phase
		compare("clear span", 1, {31'h0, (n > 680 && n <= 1050)});
		rd(1'b1, 5'h10, "control", 8'h0D);
		for (i = 0; i < 8; i++) begin
			rd(1'b0, {2'b00, i[2:0]}, "flash", 8'h00);
		end
		// Two whole internal periods of 350 cycles: half of the window is high
		n = 0;
		repeat (700) begin
			@(posedge clk_sys_i);
			#1;
			n += (refresh_clk === 1'b1) ? 1 : 0;
		end
		compare("refresh high", 350, n);
		results();
	end
endmodule : display_attribute_control_port_tb

`default_nettype wire

// >>> test/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host processor on the parallel port
// ------------------------------------------------------------
module host_bus_model (
	// Clock
	input  wire logic       clk_sys_i,
	// Port pins
	output var  logic       cs_n_o,
	output var  logic       wr_n_o,
	output var  logic       rd_n_o,
	output var  logic       sel_n_o,
	output var  logic [4:0] addr_o,
	output var  logic [7:0] data_o,
	input  wire logic [7:0] data_i
);
	initial begin
		cs_n_o  = 1'b1;
		wr_n_o  = 1'b1;
		rd_n_o  = 1'b1;
		sel_n_o = 1'b1;
		addr_o  = 5'h00;
		data_o  = 8'h00;
	end

	// Pins hold four cycles, one more than the two-stage sync chain plus the read data register need
	task automatic cycle(input logic sel_n, input logic [4:0] addr, input logic wr,
		input logic [7:0] wdata, output logic [7:0] rdata);
		@(posedge clk_sys_i);
		#1;
		sel_n_o = sel_n;
		addr_o  = addr;
		data_o  = wr ? wdata : ~data_o;
		wr_n_o  = ~wr;
		rd_n_o  = wr;
		cs_n_o  = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		// Read data is taken once settled, before the pins are released
		#1;
		rdata = data_i;
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		// Released bus must not keep showing the last byte
		data_o = ~data_o;
		repeat (4) @(posedge clk_sys_i);
	endtask : cycle
endmodule : host_bus_model

`default_nettype wire
